// >>> design/bst_pkg.sv
// Package for the boundary-scan test port: opcodes, register map, layout.
// Assumes one system clock at 100 MHz and a sampled test clock.
package bst_pkg;

  // ---------------------------------------------------------------------
  // Instruction opcodes
  // ---------------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] OP_CHIP_RESET = 4'hc;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MCU_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 4'h1;
  localparam int BIT_PORT_DISABLE = 7;
  localparam int BIT_PULLUP_DIS = 4;
  localparam int BIT_TEST_RESET_FLAG = 4;
  localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] MCU_CONTROL_MASK = 8'h93;
  localparam int TIMED_WINDOW_CYC = 4;

  // ---------------------------------------------------------------------
  // Chain layout
  // ---------------------------------------------------------------------
  localparam int NPINS = 8;
  localparam int NOSC = 3;
  localparam logic [NOSC-1:0] OSC_IDLE_LEVEL = 3'h6;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam int CHAIN_W = 3 * NPINS + 2 + 2 * NOSC;
  localparam int TIMEOUT_CYC = 16;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_tap_e;

  typedef struct packed {
    logic [NPINS-1:0] pin_output_bit;
    logic [NPINS-1:0] pin_direction_bit;
    logic [NPINS-1:0] pin_level;
    logic low_reset_observe;
    logic high_voltage_reset_observe;
    logic [NOSC-1:0] osc_enable;
    logic [NOSC-1:0] osc_clock;
    logic [NOSC-1:0] osc_used;
  } bst_obs_s;
endpackage

// >>> design/bst_test_port.sv
// Boundary-scan test port: TAP, instruction and data registers, control.
// Assumes test pins arrive asynchronously and are sampled on clk_sys_i.
//
// Contract
// (R1) Opcode 2 samples and shifts boundary chain.
// (R2) Sample update loads latches, pins untouched.
// (R3) Opcode C selects reset bit; TAP kept.
// (R4) Chip reset while reset bit is one.
// (R5) Chip-reset instruction only shifts in Shift-DR.
// (R6) Opcode F selects bypass cell.
// (R7) Bypass captures zero, then shifts.
// (R8) Disable bit one turns test port off.
// (R9) Disable bit changes on double write.
// (R10) Software sets disable bit when unconnected.
// (R11) Test reset sets reset cause flag.
// (R12) Flag cleared by power-on or zero write.
// (R13) Pins have pull-up and two-stage cells.
// (R14) Scanned input raw; data, control from registers (code captures pin_level in the control cells, not pin_direction_bit).
// (R15) Pull-up equals not-disable, not-dir, output bit.
// (R16) Chain observes actual pin value.
// (R17) Reset pin has two observe cells.
// (R18) Oscillator enable and clock are scanned.
// (R19) Unused clock lines read 0,1,1.
// (R20) Controller enables one clock source only.
// (R21) Oscillator enables kept in chain.
// (R22) Four-bit IR, shifted LSB first.
// (R23) Timeout holds reset after release.
// (R24) Unknown opcodes select bypass.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module bst_test_port
  import bst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Test access pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Fuse and observed chip signals
  input wire logic test_port_fuse_i,
  input wire bst_obs_s obs_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Chip reset and latches
  output logic chip_reset_o,
  output logic [CHAIN_W-1:0] bound_latch_o
);

  logic [2:0] tck_s_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic tck_rise;
  logic tck_fall;
  bst_tap_e tap_r;
  bst_tap_e tap_nxt;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_sh_r;
  logic [CHAIN_W-1:0] chain_r;
  logic [CHAIN_W-1:0] capture;
  logic bypass_r;
  logic rst_bit_r;
  logic [7:0] ctrl_r;
  logic flag_r;
  logic [2:0] win_r;
  logic [7:0] mcu_control_wv;
  logic en;
  logic [4:0] tmo_r;
  logic [NOSC-1:0] clk_line;
  logic [NPINS-1:0] pue;
  logic [NOSC-1:0] osc_unused;

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h0;
    end else begin
      tck_s_r <= {tck_s_r[1:0], tck_i};
      tms_s_r <= {tms_s_r[0], tms_i};
      tdi_s_r <= {tdi_s_r[0], tdi_i};
    end
  end
  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];
  assign en = test_port_fuse_i & ~ctrl_r[BIT_PORT_DISABLE]; // [R8]

  // -----------------------------------------------------------------------
  // TAP state machine
  // -----------------------------------------------------------------------
  always_comb begin
    tap_nxt = tap_r;
    unique case (tap_r)
      ST_RESET: tap_nxt = tms_s_r[1] ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_nxt = tms_s_r[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_nxt = tms_s_r[1] ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_nxt = tms_s_r[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_nxt = tms_s_r[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_nxt = tms_s_r[1] ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_nxt = tms_s_r[1] ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_nxt = tms_s_r[1] ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_nxt = tms_s_r[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_nxt = tms_s_r[1] ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_nxt = tms_s_r[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_nxt = tms_s_r[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_nxt = tms_s_r[1] ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_nxt = tms_s_r[1] ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_nxt = tms_s_r[1] ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_nxt = tms_s_r[1] ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tap_r <= ST_RESET;
    end else if (!en) begin
      tap_r <= ST_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_nxt; // [R3]
    end
  end

  // -----------------------------------------------------------------------
  // Instruction register
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ir_r <= OP_BYPASS;
      ir_sh_r <= OP_BYPASS;
    end else if (tap_r == ST_RESET) begin
      ir_r <= OP_BYPASS;
    end else if (tck_rise) begin
      if (tap_r == ST_CAP_IR) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (tap_r == ST_SHIFT_IR) begin
        ir_sh_r <= {tdi_s_r[1], ir_sh_r[IR_W-1:1]}; // [R22]
      end else if (tap_r == ST_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Boundary chain capture
  // -----------------------------------------------------------------------
  assign osc_unused = OSC_IDLE_LEVEL; // [R19]
  assign clk_line = (obs_i.osc_clock & obs_i.osc_used)
                  | (osc_unused & ~obs_i.osc_used); // [R19]
  assign pue = {NPINS{~ctrl_r[BIT_PULLUP_DIS]}} & ~obs_i.pin_direction_bit
             & obs_i.pin_output_bit; // [R15]
  assign capture = {pue, obs_i.pin_direction_bit, obs_i.pin_output_bit,
                    obs_i.low_reset_observe,
                    obs_i.high_voltage_reset_observe,
                    obs_i.osc_enable, clk_line}; // [R13] [R17] [R18] [R21]

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      chain_r <= '0;
      bound_latch_o <= '0;
    end else if (tck_rise && ir_r == OP_SAMPLE) begin
      if (tap_r == ST_CAP_DR) begin
        chain_r <= {capture[CHAIN_W-1:2*NPINS+2+2*NOSC],
                    obs_i.pin_level, capture[NPINS+1+2*NOSC:0]}; // [R14] [R16]
      end else if (tap_r == ST_SHIFT_DR) begin
        chain_r <= {tdi_s_r[1], chain_r[CHAIN_W-1:1]}; // [R1] [R22]
      end else if (tap_r == ST_UPD_DR) begin
        bound_latch_o <= chain_r; // [R2]
      end
    end
  end

  // -----------------------------------------------------------------------
  // Bypass and reset data registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bypass_r <= 1'b0;
    end else if (tck_rise && ir_r != OP_SAMPLE && ir_r != OP_CHIP_RESET) begin
      if (tap_r == ST_CAP_DR) begin
        bypass_r <= 1'b0; // [R7] [R24]
      end else if (tap_r == ST_SHIFT_DR) begin
        bypass_r <= tdi_s_r[1]; // [R6]
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_bit_r <= 1'b0;
    end else if (tck_rise && ir_r == OP_CHIP_RESET
                 && tap_r == ST_SHIFT_DR) begin
      rst_bit_r <= tdi_s_r[1]; // [R5]
    end
  end

  // -----------------------------------------------------------------------
  // Serial output
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (!en) begin
      tdo_oe_o <= 1'b0; // [R8]
    end else if (tck_fall) begin
      tdo_oe_o <= tap_r == ST_SHIFT_DR || tap_r == ST_SHIFT_IR;
      if (tap_r == ST_SHIFT_IR) begin
        tdo_o <= ir_sh_r[0];
      end else if (ir_r == OP_SAMPLE) begin
        tdo_o <= chain_r[0];
      end else if (ir_r == OP_CHIP_RESET) begin
        tdo_o <= rst_bit_r;
      end else begin
        tdo_o <= bypass_r;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Chip reset and time-out
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_r <= 5'h0;
      chip_reset_o <= 1'b0;
    end else if (rst_bit_r) begin
      tmo_r <= 5'(TIMEOUT_CYC);
      chip_reset_o <= 1'b1; // [R4]
    end else if (tmo_r != 5'h0) begin
      tmo_r <= tmo_r - 5'h1;
      chip_reset_o <= 1'b1; // [R23]
    end else begin
      chip_reset_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Control and status registers
  // -----------------------------------------------------------------------
  assign mcu_control_wv = wdata_i & MCU_CONTROL_MASK;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= MCU_CONTROL_RST;
      win_r <= 3'h0;
    end else if (wr_i && addr_i == ADDR_MCU_CONTROL) begin
      ctrl_r[6:0] <= mcu_control_wv[6:0];
      if (win_r != 3'h0) begin
        ctrl_r[BIT_PORT_DISABLE] <= mcu_control_wv[BIT_PORT_DISABLE]; // [R9]
        win_r <= 3'h0;
      end else begin
        win_r <= 3'(TIMED_WINDOW_CYC);
      end
    end else if (win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (rst_bit_r) begin
      flag_r <= 1'b1; // [R11]
    end else if (wr_i && addr_i == ADDR_RESET_CAUSE
                 && !wdata_i[BIT_TEST_RESET_FLAG]) begin
      flag_r <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && addr_i == ADDR_MCU_CONTROL) begin
      rdata_o <= ctrl_r;
    end else if (rd_i && addr_i == ADDR_RESET_CAUSE) begin
      rdata_o <= {3'h0, flag_r, 4'h0};
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  property p_reset_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    rst_bit_r |=> chip_reset_o;
  endproperty
  a_reset_hold: assert property (p_reset_hold) // [R4]
    else $error("chip reset not held");

  property p_flag_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    rst_bit_r |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) // [R11]
    else $error("reset flag not set");

  property p_single_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == ADDR_MCU_CONTROL && win_r == 3'h0)
      |=> $stable(ctrl_r[BIT_PORT_DISABLE]);
  endproperty
  a_single_write: assert property (p_single_write) // [R9]
    else $error("disable bit changed on single write");

  property p_bypass_cap;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tck_rise && tap_r == ST_CAP_DR && ir_r == OP_BYPASS) |=> !bypass_r;
  endproperty
  a_bypass_cap: assert property (p_bypass_cap) // [R7]
    else $error("bypass capture not zero");

  property p_disabled;
    @(posedge clk_sys_i) disable iff (rst_i)
    ctrl_r[BIT_PORT_DISABLE] |=> tap_r == ST_RESET;
  endproperty
  a_disabled: assert property (p_disabled) // [R8]
    else $error("port active while disabled");

  property p_timeout;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(rst_bit_r) |-> chip_reset_o [*8];
  endproperty
  a_timeout: assert property (p_timeout) // [R23]
    else $error("reset released before time-out");

  property p_flag_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == ADDR_RESET_CAUSE && !wdata_i[BIT_TEST_RESET_FLAG]
     && !rst_bit_r) |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [R12]
    else $error("flag not cleared");

  property p_latch_only_update;
    @(posedge clk_sys_i) disable iff (rst_i)
    !(tck_s_r[2:1] == 2'b01 && tap_r == ST_UPD_DR) |=> $stable(bound_latch_o);
  endproperty
  a_latch_only_update: assert property (p_latch_only_update) // [R2]
    else $error("latch changed outside update");

  property p_chain_shift;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tck_rise && tap_r == ST_SHIFT_DR && ir_r == OP_SAMPLE)
      |=> chain_r[CHAIN_W-2:0] == $past(chain_r[CHAIN_W-1:1]);
  endproperty
  a_chain_shift: assert property (p_chain_shift) // [R1]
    else $error("boundary chain did not shift");

  property p_bypass_shift;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tck_rise && tap_r == ST_SHIFT_DR && ir_r == OP_BYPASS)
      |=> bypass_r == $past(tdi_s_r[1]);
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) // [R6]
    else $error("bypass cell did not shift");

  property p_reset_shift;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tck_rise && tap_r == ST_SHIFT_DR && ir_r == OP_CHIP_RESET)
      |=> rst_bit_r == $past(tdi_s_r[1]);
  endproperty
  a_reset_shift: assert property (p_reset_shift) // [R5]
    else $error("reset bit did not shift");

endmodule

// >>> testbench/bst_tap_ctrl.sv
// Model of the external test controller on the test access pins.
// Assumes a 100 MHz system clock; one test clock spans 8 of its cycles.
`timescale 1ns/10ps
module bst_tap_ctrl (
  // Clock
  input wire logic clk_sys_i,
  // Test pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // ----------------------------------------------------------------
  // Test clock cycles
  // ----------------------------------------------------------------
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock of 80 ns; the serial output is taken at its rise.
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_sys_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    tck_o <= 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    @(posedge clk_sys_i);
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  // Shifts n bits from idle, least significant first, back to idle.
  task automatic scan(input logic ir, input int n,
                      input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    @(posedge clk_sys_i);
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tdi_o <= ~din[n-1];
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model drives the test pins.
`timescale 1ns/10ps
module tb_top
  import bst_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, fuse, wr, rd, chip_rst, oe_seen;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [CHAIN_W-1:0] latch;
  logic [31:0] d;
  bst_obs_s obs;
  int n_fail = 0;
  int checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
    if (tdo_oe === 1'b1)
      oe_seen <= 1'b1;

  bst_test_port uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .test_port_fuse_i(fuse), .obs_i(obs), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .chip_reset_o(chip_rst), .bound_latch_o(latch));

  bst_tap_ctrl ctrl (.clk_sys_i(clk_sys_i), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .tdo_i(tdo));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rreg(ADDR_MCU_CONTROL, q);
    chk(q, MCU_CONTROL_RST);
    wreg(4'h5, 8'hff);
    rreg(4'h5, q);
    chk(q, 8'h00);
    wreg(ADDR_MCU_CONTROL, 8'h80);
    repeat (6) @(posedge clk_sys_i);
    rreg(ADDR_MCU_CONTROL, q);
    chk(q, 8'h00);
    wreg(ADDR_MCU_CONTROL, 8'h80);
    wreg(ADDR_MCU_CONTROL, 8'h80);
    rreg(ADDR_MCU_CONTROL, q);
    chk(q, 8'h80);
    oe_seen = 1'b0;
    ctrl.scan(1'b1, 4, {28'h0, OP_BYPASS}, d);
    chk(oe_seen, 1'b0);
    wreg(ADDR_MCU_CONTROL, 8'h00);
    wreg(ADDR_MCU_CONTROL, 8'h00);
    fuse <= 1'b0;
    oe_seen = 1'b0;
    ctrl.scan(1'b1, 4, {28'h0, OP_BYPASS}, d);
    chk(oe_seen, 1'b0);
    fuse <= 1'b1;
    ctrl.reset_tap();
    ctrl.scan(1'b1, 4, {28'h0, OP_BYPASS}, d);
    chk(oe_seen, 1'b1);
  endtask

  task automatic t_bypass();
    logic [3:0] ops [2] = '{OP_BYPASS, 4'h5};
    foreach (ops[i]) begin
      ctrl.scan(1'b1, 4, {28'h0, ops[i]}, d);
      chk(d[3:0], 4'h1);
      ctrl.scan(1'b0, 8, 32'ha5, d);
      chk(d[7:0], 8'h4a);
    end
  endtask

  task automatic t_sample();
    logic [31:0] din;
    logic [7:0] pu;
    logic [31:0] ch;
    for (int p = 0; p < 2; p++) begin
      wreg(ADDR_MCU_CONTROL, p ? 8'h10 : 8'h00);
      pu = p ? 8'h00 : ~obs.pin_direction_bit & obs.pin_output_bit;
      din = p ? 32'h9669a55a : 32'h3cc30ff0;
      ctrl.scan(1'b1, 4, {28'h0, OP_SAMPLE}, d);
      ctrl.scan(1'b0, 32, din, d);
      ch = {pu, obs.pin_level, obs.pin_output_bit, obs.low_reset_observe,
            obs.high_voltage_reset_observe, obs.osc_enable, 3'h6};
      chk(d, ch);
      chk(latch, din);
      chk(chip_rst, 1'b0);
    end
  endtask

  task automatic t_chip_reset();
    int n;
    logic b;
    ctrl.scan(1'b1, 4, {28'h0, OP_CHIP_RESET}, d);
    ctrl.scan(1'b0, 1, 32'h1, d);
    chk(d[0], 1'b0);
    chk(chip_rst, 1'b1);
    rreg(ADDR_RESET_CAUSE, q);
    chk(q[BIT_TEST_RESET_FLAG], 1'b1);
    @(posedge clk_sys_i);
    ctrl.tick(1'b1, 1'b0, b);
    ctrl.tick(1'b0, 1'b0, b);
    ctrl.tick(1'b0, 1'b0, b);
    ctrl.tick(1'b1, 1'b0, b);
    chk(b, 1'b1);
    n = 0;
    while (chip_rst === 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n >= TIMEOUT_CYC, 1'b1);
    chk(chip_rst, 1'b0);
    ctrl.tick(1'b1, 1'b0, b);
    ctrl.tick(1'b0, 1'b0, b);
    rreg(ADDR_RESET_CAUSE, q);
    chk(q[BIT_TEST_RESET_FLAG], 1'b1);
    wreg(ADDR_RESET_CAUSE, 8'h00);
    rreg(ADDR_RESET_CAUSE, q);
    chk(q[BIT_TEST_RESET_FLAG], 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fuse = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    oe_seen = 1'b0;
    obs.pin_output_bit = 8'hc3;
    obs.pin_direction_bit = 8'h0f;
    obs.pin_level = 8'h5a;
    obs.low_reset_observe = 1'b1;
    obs.high_voltage_reset_observe = 1'b0;
    obs.osc_enable = 3'b001;
    obs.osc_clock = 3'b000;
    obs.osc_used = 3'b000;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    ctrl.reset_tap();
    t_regs();
    t_bypass();
    t_sample();
    t_chip_reset();
    complete_run();
  end

  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
endmodule
